// ---- hdl/pt_timer.sv ----
// periodic timer: 10-bit up-counter, two comparators, pin modes,
// byte-wide register port
// assumes all inputs synchronous to mclk_i except the three pins, which
// pass through pt_edge_sync; high-speed clock taken equal to mclk_i
//
// Operation
// R01: counter is a 10-bit up-counter advanced by the selected clock source.
// R02: comparators A and P compare all ten counter bits.
// R03: software cannot load the counter; on-bit rising clears it.
// R04: on bit low stops counting; counter keeps its value.
// R05: pause bit freezes the counter; clearing resumes from there.
// R06: three-bit clock select picks system, divided, sub or external edges.
// R07: on-bit rising restores initial pin level in compare, PWM, pulse modes.
// R08: two-bit mode field selects compare, capture, PWM/pulse, timer.
// R09: software should turn the timer off before changing mode.
// R10: compare mode A match: none, low, high or toggle on pin.
// R11: PWM mode pin function: inactive, active, PWM, single pulse.
// R12: capture mode trigger: rising, falling, both edges, or disabled.
// R13: in PWM mode change pin function only while off.
// R14: output control bit: initial level, or active level in PWM.
// R15: requested level equal to current level leaves pin unchanged.
// R16: polarity bit inverts the pin; no effect in timer mode.
// R17: capture source: capture pin when 0, external clock pin when 1.
// R18: clear select 1 clears on A; 0 on P or overflow if P zero.
// R19: clear select ignored in PWM and single pulse modes.
// R20: automatic counter clear also raises an interrupt request.
// R21: in timer mode the output pin is not driven.
// R22: second output pin is always the inverse of the main output.
// R23: with clear select 1 only the A flag is ever raised; capture mode here ignores clear select and still raises P.
// R24: compare A zero: counter overflows at 3FF without the A flag.
// R25: external clock and capture pins are synchronised before use.
// R26: unimplemented control and high-byte bits read zero, writes ignored.
`include "pt_defines.svh"
module pt_timer
    import pt_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [`PT_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic external_clock_pin_i,
    input wire logic capture_input_pin_i,
    input wire logic sub_clock_i,
    output logic timer_output_pin_o,
    output logic timer_output_pin_en_o,
    output logic inverted_output_pin_o,
    output logic compare_a_irq_o,
    output logic compare_p_irq_o
);

    // low and high register bytes of a 10-bit value
    function automatic logic [7:0] lo_byte(input logic [`PT_CNT_W-1:0] v);
        lo_byte = v[7:0];
    endfunction : lo_byte

    function automatic logic [7:0] hi_byte(input logic [`PT_CNT_W-1:0] v);
        hi_byte = {6'h00, v[`PT_CNT_W-1:8]} & `PT_HI_MASK;
    endfunction : hi_byte

    pt_state_t s_ff;
    pt_state_t nxt_s;

    logic ext_rise;
    logic ext_fall;
    logic cap_rise;
    logic cap_fall;
    logic sub_rise;

    // pins are asynchronous to mclk_i, so each is synchronised first [R25]
    pt_edge_sync u_ext_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .pin_i(external_clock_pin_i),
        .rise_o(ext_rise),
        .fall_o(ext_fall)
    );

    pt_edge_sync u_cap_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .pin_i(capture_input_pin_i),
        .rise_o(cap_rise),
        .fall_o(cap_fall)
    );

    pt_edge_sync u_sub_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .pin_i(sub_clock_i),
        .rise_o(sub_rise),
        .fall_o()
    );

    // whole next-state computation
    always_comb begin
        logic on;
        logic on_rise;
        logic tick;
        logic run;
        logic [1:0] mode;
        logic [1:0] pinf;
        logic init;
        logic clrsel;
        logic trg_r;
        logic trg_f;
        logic cap_evt;
        logic match_a;
        logic match_p;
        logic ovf;
        logic per_end;
        logic clr;
        logic set_a;
        logic set_p;
        logic act;
        logic lvl;

        nxt_s = s_ff;
        // every local starts from a known value so no path can leave a latch
        on = 1'b0;
        on_rise = 1'b0;
        tick = 1'b0;
        run = 1'b0;
        mode = `PT_MODE_CMP;
        pinf = `PT_PF_0;
        init = 1'b0;
        clrsel = 1'b0;
        trg_r = 1'b0;
        trg_f = 1'b0;
        cap_evt = 1'b0;
        match_a = 1'b0;
        match_p = 1'b0;
        ovf = 1'b0;
        per_end = 1'b0;
        clr = 1'b0;
        set_a = 1'b0;
        set_p = 1'b0;
        act = 1'b0;
        lvl = 1'b0;
        on = s_ff.ctrl0[`PT_C0_ON];
        on_rise = on & ~s_ff.on_d;
        mode = s_ff.ctrl1[`PT_C1_MODE];
        pinf = s_ff.ctrl1[`PT_C1_PINF];
        init = s_ff.ctrl1[`PT_C1_INIT];
        clrsel = s_ff.ctrl1[`PT_C1_CLRSEL];
        nxt_s.on_d = on;
        nxt_s.div = s_ff.div + `PT_DIV_STEP;

        // counter clock selection; high-speed clock is mclk_i here [R06]
        unique case (s_ff.ctrl0[`PT_C0_CKS])
            `PT_CKS_SYS4: tick = (s_ff.div[1:0] == `PT_DIV4_END);
            `PT_CKS_SYS: tick = 1'b1;
            `PT_CKS_H16: tick = (s_ff.div[3:0] == `PT_DIV16_END);
            `PT_CKS_H64: tick = (s_ff.div == `PT_DIV64_END);
            `PT_CKS_SUB0, `PT_CKS_SUB1: tick = sub_rise;
            `PT_CKS_EXT_R: tick = ext_rise;
            `PT_CKS_EXT_F: tick = ext_fall;
        endcase

        // off or paused holds the count; prescaler runs regardless
        run = on & ~s_ff.ctrl0[`PT_C0_PAUSE] & tick; // [R04] [R05]

        // capture source and edge choice [R17] [R12]
        trg_r = s_ff.ctrl1[`PT_C1_CAPSRC] ? ext_rise : cap_rise;
        trg_f = s_ff.ctrl1[`PT_C1_CAPSRC] ? ext_fall : cap_fall;
        unique case (pinf)
            `PT_PF_0: cap_evt = trg_r;
            `PT_PF_1: cap_evt = trg_f;
            `PT_PF_2: cap_evt = trg_r | trg_f;
            `PT_PF_3: cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt & on & (mode == `PT_MODE_CAP);

        // both comparators see all ten bits; zero A never matches [R02] [R24]
        match_a = run & (s_ff.cnt == s_ff.cmp_a) & (s_ff.cmp_a != `PT_CNT_ZERO);
        match_p = run & (s_ff.cnt == s_ff.per) & (s_ff.per != `PT_CNT_ZERO);
        ovf = run & (s_ff.cnt == `PT_CNT_MAX);
        // pwm period of per counts, or 1024 when per is zero
        per_end = (s_ff.per == `PT_CNT_ZERO) ? ovf
                : run & (s_ff.cnt == s_ff.per - `PT_CNT_ONE);

        // clear source and flags per mode [R08]
        clr = 1'b0;
        set_a = 1'b0;
        set_p = 1'b0;
        unique case (mode)
            `PT_MODE_PWM: begin
                // clear select has no say here [R19]
                clr = per_end;
                set_p = per_end;
                set_a = match_a;
            end
            `PT_MODE_CAP: begin
                clr = match_p | ((s_ff.per == `PT_CNT_ZERO) & ovf);
                set_p = clr;
                set_a = cap_evt;
            end
            default: begin
                if (clrsel) begin
                    // only the A flag exists in this setting [R18] [R23]
                    clr = match_a;
                    set_a = match_a;
                end else begin
                    // overflow clears only when the period is zero [R18]
                    clr = match_p | ((s_ff.per == `PT_CNT_ZERO) & ovf);
                    set_p = clr;
                    set_a = match_a;
                end
            end
        endcase

        // counter: no load path, on-bit rising zeroes it [R03] [R01]
        if (on_rise) begin
            nxt_s.cnt = `PT_CNT_RST;
        end else if (run) begin
            nxt_s.cnt = clr ? `PT_CNT_ZERO : s_ff.cnt + `PT_CNT_ONE;
        end

        // interrupt requests as one-cycle pulses on each auto clear [R20]
        nxt_s.irq_a = set_a;
        nxt_s.irq_p = set_p;

        // output level in compare mode; equal request leaves pin as is
        lvl = s_ff.lvl;
        if (on_rise) begin
            lvl = init; // [R07] [R14]
        end else if (match_a) begin
            unique case (pinf)
                `PT_PF_0: lvl = s_ff.lvl;
                `PT_PF_1: lvl = 1'b0; // [R10] [R15]
                `PT_PF_2: lvl = 1'b1; // [R10] [R15]
                `PT_PF_3: lvl = ~s_ff.lvl; // [R10]
            endcase
        end
        nxt_s.lvl = lvl;

        // single pulse: active from on-bit rising until the A match
        if (on_rise) begin
            nxt_s.sp = 1'b1;
        end else if (match_a) begin
            nxt_s.sp = 1'b0;
        end

        // pwm active while below duty; pinf changes while on are unsafe
        unique case (pinf)
            `PT_PF_0: act = 1'b0; // [R11]
            `PT_PF_1: act = 1'b1; // [R11]
            `PT_PF_2: act = on & (nxt_s.cnt < s_ff.cmp_a); // [R11]
            `PT_PF_3: act = nxt_s.sp; // [R11]
        endcase

        // pin drive: polarity only in driven modes, twin always inverse
        if (mode == `PT_MODE_TMR) begin
            nxt_s.pin = 1'b0; // [R21]
            nxt_s.pin_en = 1'b0; // [R16]
        end else if (mode == `PT_MODE_PWM) begin
            nxt_s.pin = (act ? init : ~init) ^ s_ff.ctrl1[`PT_C1_POL]; // [R14] [R16]
            nxt_s.pin_en = 1'b1;
        end else begin
            nxt_s.pin = lvl ^ s_ff.ctrl1[`PT_C1_POL]; // [R16]
            nxt_s.pin_en = 1'b1;
        end
        nxt_s.pin_n = ~nxt_s.pin; // [R22]

        // register writes; unimplemented bits dropped [R26]
        if (wr_i) begin
            unique case (addr_i)
                `PT_ADDR_CTRL0: nxt_s.ctrl0 = wdata_i & `PT_CTRL0_MASK;
                `PT_ADDR_CTRL1: nxt_s.ctrl1 = wdata_i;
                `PT_ADDR_CMPA_LO: nxt_s.cmp_a[7:0] = wdata_i;
                `PT_ADDR_CMPA_HI: nxt_s.cmp_a[`PT_CNT_W-1:8] = wdata_i[1:0];
                `PT_ADDR_PER_LO: nxt_s.per[7:0] = wdata_i;
                `PT_ADDR_PER_HI: nxt_s.per[`PT_CNT_W-1:8] = wdata_i[1:0];
                default: ;
            endcase
        end

        // capture overwrites the A value after any software write
        if (cap_evt) begin
            nxt_s.cmp_a = s_ff.cnt;
        end

        // sticky flags: a set in the clearing cycle wins
        if (wr_i && addr_i == `PT_ADDR_STATUS) begin
            if (wdata_i[`PT_ST_FLAG_A]) nxt_s.flag_a = 1'b0;
            if (wdata_i[`PT_ST_FLAG_P]) nxt_s.flag_p = 1'b0;
        end
        if (set_a) nxt_s.flag_a = 1'b1;
        if (set_p) nxt_s.flag_p = 1'b1;

        // read data stands one cycle after the strobe, zero otherwise
        nxt_s.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `PT_ADDR_CTRL0: nxt_s.rdata = s_ff.ctrl0 & `PT_CTRL0_MASK; // [R26]
                `PT_ADDR_CTRL1: nxt_s.rdata = s_ff.ctrl1;
                `PT_ADDR_CNT_LO: nxt_s.rdata = lo_byte(s_ff.cnt);
                `PT_ADDR_CNT_HI: nxt_s.rdata = hi_byte(s_ff.cnt); // [R26]
                `PT_ADDR_CMPA_LO: nxt_s.rdata = lo_byte(s_ff.cmp_a);
                `PT_ADDR_CMPA_HI: nxt_s.rdata = hi_byte(s_ff.cmp_a); // [R26]
                `PT_ADDR_PER_LO: nxt_s.rdata = lo_byte(s_ff.per);
                `PT_ADDR_PER_HI: nxt_s.rdata = hi_byte(s_ff.per); // [R26]
                `PT_ADDR_STATUS: nxt_s.rdata = {6'h00, s_ff.flag_p, s_ff.flag_a};
                default: nxt_s.rdata = 8'h00;
            endcase
        end
    end

    // single state register; the twin pin stays the inverse even in reset
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_ff <= '{pin_n: 1'b1, default: '0}; // [R22]
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from flip-flops
    assign rdata_o = s_ff.rdata;
    assign timer_output_pin_o = s_ff.pin;
    assign timer_output_pin_en_o = s_ff.pin_en;
    assign inverted_output_pin_o = s_ff.pin_n;
    assign compare_a_irq_o = s_ff.irq_a;
    assign compare_p_irq_o = s_ff.irq_p;

endmodule : pt_timer

// ---- include/pt_defines.svh ----
// constants of the periodic timer: register offsets, field positions,
// field codes and reset values
// assumes an 8-bit register port with a 4-bit word address
`ifndef PT_DEFINES_SVH
`define PT_DEFINES_SVH

`define PT_ADDR_W 4
`define PT_CNT_W 10
`define PT_DIV_W 6

// register offsets
`define PT_ADDR_CTRL0 4'h0
`define PT_ADDR_CTRL1 4'h1
`define PT_ADDR_CNT_LO 4'h2
`define PT_ADDR_CNT_HI 4'h3
`define PT_ADDR_CMPA_LO 4'h4
`define PT_ADDR_CMPA_HI 4'h5
`define PT_ADDR_PER_LO 4'h6
`define PT_ADDR_PER_HI 4'h7
`define PT_ADDR_STATUS 4'h8

// reset values and implemented-bit masks
`define PT_CTRL_RST 8'h00
`define PT_CNT_RST 10'h000
`define PT_CTRL0_MASK 8'hF8
`define PT_HI_MASK 8'h03
`define PT_CNT_MAX 10'h3FF
`define PT_CNT_ZERO 10'h000
`define PT_CNT_ONE 10'h001

// control 0 fields
`define PT_C0_PAUSE 7
`define PT_C0_CKS 6:4
`define PT_C0_ON 3

// control 1 fields
`define PT_C1_MODE 7:6
`define PT_C1_PINF 5:4
`define PT_C1_INIT 3
`define PT_C1_POL 2
`define PT_C1_CAPSRC 1
`define PT_C1_CLRSEL 0

// status fields, write one to clear
`define PT_ST_FLAG_A 0
`define PT_ST_FLAG_P 1

// clock source codes
`define PT_CKS_SYS4 3'h0
`define PT_CKS_SYS 3'h1
`define PT_CKS_H16 3'h2
`define PT_CKS_H64 3'h3
`define PT_CKS_SUB0 3'h4
`define PT_CKS_SUB1 3'h5
`define PT_CKS_EXT_R 3'h6
`define PT_CKS_EXT_F 3'h7

// prescaler terminal values
`define PT_DIV4_END 2'h3
`define PT_DIV16_END 4'hF
`define PT_DIV64_END 6'h3F
`define PT_DIV_STEP 6'h01

// mode codes
`define PT_MODE_CMP 2'h0
`define PT_MODE_CAP 2'h1
`define PT_MODE_PWM 2'h2
`define PT_MODE_TMR 2'h3

// pin function codes
`define PT_PF_0 2'h0
`define PT_PF_1 2'h1
`define PT_PF_2 2'h2
`define PT_PF_3 2'h3

`endif

// ---- include/pt_pkg.sv ----
// types of the periodic timer: state records of the core and synchroniser
// assumes pt_defines.svh on the include path
`include "pt_defines.svh"

package pt_pkg;

    // whole state of the timer core
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [`PT_CNT_W-1:0] cmp_a;
        logic [`PT_CNT_W-1:0] per;
        logic [`PT_CNT_W-1:0] cnt;
        logic [`PT_DIV_W-1:0] div;
        logic on_d;
        logic lvl;
        logic sp;
        logic flag_a;
        logic flag_p;
        logic irq_a;
        logic irq_p;
        logic [7:0] rdata;
        logic pin;
        logic pin_n;
        logic pin_en;
    } pt_state_t;

    // whole state of one pin synchroniser
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic rise;
        logic fall;
    } pt_sync_t;

endpackage : pt_pkg

// ---- hdl/pt_edge_sync.sv ----
// two-stage synchroniser with edge detection for one pin
// assumes the pin may change at any time relative to mclk_i
module pt_edge_sync
    import pt_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic pin_i,
    output logic rise_o,
    output logic fall_o
);

    pt_sync_t s_ff;
    pt_sync_t nxt_s;

    // edges are taken from stages two and three only, never from stage one
    always_comb begin
        nxt_s = s_ff;
        nxt_s.s1 = pin_i;
        nxt_s.s2 = s_ff.s1;
        nxt_s.s3 = s_ff.s2;
        nxt_s.rise = s_ff.s2 & ~s_ff.s3;
        nxt_s.fall = ~s_ff.s2 & s_ff.s3;
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign rise_o = s_ff.rise;
    assign fall_o = s_ff.fall;

endmodule : pt_edge_sync

// ---- dv/pt_chk.sv ----
// port checker of the periodic timer, with a bus shadow of control and A
// assumes a bind to pt_timer; capture updates of A are not shadowed
`include "pt_defines.svh"
module pt_chk (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [`PT_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic timer_output_pin_o,
    input wire logic timer_output_pin_en_o,
    input wire logic inverted_output_pin_o,
    input wire logic compare_a_irq_o,
    input wire logic compare_p_irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] c0_ff;
    logic [7:0] c1_ff;
    logic [9:0] a_ff;
    // shadow of what software wrote, updated on the same edge as the design
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            c0_ff <= 8'h00;
            c1_ff <= 8'h00;
            a_ff <= 10'h000;
        end else if (wr_i) begin
            case (addr_i)
                `PT_ADDR_CTRL0: c0_ff <= wdata_i;
                `PT_ADDR_CTRL1: c1_ff <= wdata_i;
                `PT_ADDR_CMPA_LO: a_ff[7:0] <= wdata_i;
                `PT_ADDR_CMPA_HI: a_ff[9:8] <= wdata_i[1:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    // conditions held two or three cycles so that pulses in flight have drained
    a_twin_inverse: assert property (inverted_output_pin_o != timer_output_pin_o)
        else $error("inverted pin equals main pin");
    a_ctrl0_unused: assert property (rd_i && addr_i == `PT_ADDR_CTRL0 |=> rdata_o[2:0] == 3'h0)
        else $error("unused control bits read nonzero");
    a_high_unused: assert property (rd_i && addr_i inside {`PT_ADDR_CNT_HI, `PT_ADDR_CMPA_HI,
        `PT_ADDR_PER_HI} |=> rdata_o[7:2] == 6'h00)
        else $error("unused high byte bits read nonzero");
    a_timer_undriven: assert property ((c1_ff[7:6] == `PT_MODE_TMR)[*2] |->
        !timer_output_pin_en_o && !timer_output_pin_o)
        else $error("pin driven in timer mode");
    a_clrsel_no_p: assert property ((c1_ff[0] && c1_ff[7:6] != `PT_MODE_PWM)[*3] |->
        !compare_p_irq_o)
        else $error("period request with clear on A");
    a_zero_a_silent: assert property ((a_ff == 10'h000 && c1_ff[7:6] inside {`PT_MODE_CMP,
        `PT_MODE_TMR})[*3] |-> !compare_a_irq_o)
        else $error("A request with compare A zero");
    a_off_silent: assert property ((!c0_ff[3] || c0_ff[7])[*3] |-> !compare_p_irq_o)
        else $error("period request while stopped");
    a_on_init: assert property ($rose(c0_ff[3]) && c1_ff[7:6] == `PT_MODE_CMP |->
        ##[1:3] timer_output_pin_o == (c1_ff[3] ^ c1_ff[2]))
        else $error("pin not at initial level after start");
endmodule : pt_chk

// ---- dv/pt_pins_model.sv ----
// far side of the timer pins: external clock, capture source, sub clock
// assumes the bench steers ext_run and calls set_cap hierarchically
module pt_pins_model (
    output logic ext_clk_o,
    output logic cap_o,
    output logic sub_clk_o
);
    timeunit 1ns;
    timeprecision 100ps;
    bit ext_run = 1'b0;
    initial begin
        ext_clk_o = 1'b0;
        cap_o = 1'b0;
        sub_clk_o = 1'b0;
    end
    // sub clock runs free, 500 ns period, edges on system falling edges, away from the rising edges
    always #250 sub_clk_o = !sub_clk_o;
    // external clock toggles only while enabled and comes to rest low
    always #150 if (ext_run || ext_clk_o) ext_clk_o = !ext_clk_o;
    // one level change of the capture source, off any system edge
    task automatic set_cap(input logic v);
        #37 cap_o = v;
    endtask : set_cap
endmodule : pt_pins_model

// ---- dv/periodic_timer_module_tb.sv ----
// self-checking bench: registers, clock sources, pin modes, clearing, capture
// assumes pt_timer, pt_chk and pt_pins_model compiled before it
`include "pt_defines.svh"
module periodic_timer_module_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic ext_pin, cap_pin, sub_clk, pin_o, pin_en_o, pin_n_o, irq_a, irq_p;
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    always #25 mclk_i = !mclk_i;
    pt_timer u_pt_timer (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .external_clock_pin_i(ext_pin),
        .capture_input_pin_i(cap_pin), .sub_clock_i(sub_clk), .timer_output_pin_o(pin_o),
        .timer_output_pin_en_o(pin_en_o), .inverted_output_pin_o(pin_n_o),
        .compare_a_irq_o(irq_a), .compare_p_irq_o(irq_p));
    pt_pins_model u_pt_pins_model (.ext_clk_o(ext_pin), .cap_o(cap_pin), .sub_clk_o(sub_clk));
    task automatic chk(input logic [9:0] seen, input logic [9:0] want);
        checked++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [9:0] v);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 v = {2'h0, rdata_o};
    endtask : rd
    // bounded wait for one request pulse; c is the cycles it took
    task automatic wait_irq(input bit p, output int c);
        c = 0;
        do begin
            @(posedge mclk_i);
            #1 c++;
        end while ((p ? irq_p : irq_a) !== 1'b1 && c < 3000);
    endtask : wait_irq
    // stop first, since mode and pin function may change only while off
    task automatic cfg(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p,
        input logic [7:0] c0);
        wr(`PT_ADDR_CTRL0, 8'h00);
        wr(`PT_ADDR_CTRL1, c1);
        wr(`PT_ADDR_CMPA_LO, a[7:0]);
        wr(`PT_ADDR_CMPA_HI, {6'h00, a[9:8]});
        wr(`PT_ADDR_PER_LO, p[7:0]);
        wr(`PT_ADDR_PER_HI, {6'h00, p[9:8]});
        wr(`PT_ADDR_CTRL0, c0);
    endtask : cfg
    task automatic t_regs;
        logic [9:0] v;
        rd(`PT_ADDR_CTRL1, v);
        chk(v, 10'h000);
        wr(`PT_ADDR_CTRL1, 8'hFF);
        rd(`PT_ADDR_CTRL1, v);
        chk(v, 10'h0FF);
        wr(`PT_ADDR_CTRL0, 8'h47);
        rd(`PT_ADDR_CTRL0, v);
        chk(v, 10'h040);
        wr(`PT_ADDR_CMPA_HI, 8'hFF);
        rd(`PT_ADDR_CMPA_HI, v);
        chk(v, 10'h003);
        wr(`PT_ADDR_CNT_LO, 8'hFF);
        rd(`PT_ADDR_CNT_LO, v);
        chk(v, 10'h000);
        rd(4'hF, v);
        chk(v, 10'h000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_clocks;
        int c;
        int sp[8] = '{16, 4, 64, 256, 40, 40, 24, 24};
        for (int k = 0; k < 8; k++) begin
            u_pt_pins_model.ext_run = (k > 5);
            cfg(8'h00, 10'h000, 10'h003, {1'b0, k[2:0], 4'h8});
            wait_irq(1'b1, c);
            wait_irq(1'b1, c);
            chk(c[9:0], sp[k][9:0]);
        end
        u_pt_pins_model.ext_run = 1'b0;
        $display("test clocks done");
    endtask : t_clocks
    task automatic t_hold;
        int c;
        logic [9:0] v, w;
        cfg(8'h00, 10'h000, 10'h000, 8'h18);
        wait_irq(1'b1, c);
        wait_irq(1'b1, c);
        chk(c[9:0] == 10'h000 ? 10'h000 : 10'h001, 10'h000);
        chk(c[10:0] == 11'h400, 1'b1);
        wr(`PT_ADDR_CTRL0, 8'h98);
        rd(`PT_ADDR_CNT_LO, v);
        repeat (5) @(posedge mclk_i);
        rd(`PT_ADDR_CNT_LO, w);
        chk(w, v);
        wr(`PT_ADDR_CTRL0, 8'h10);
        rd(`PT_ADDR_CNT_LO, v);
        repeat (5) @(posedge mclk_i);
        rd(`PT_ADDR_CNT_LO, w);
        chk(w, v);
        rd(`PT_ADDR_STATUS, v);
        chk(v, 10'h002);
        wr(`PT_ADDR_STATUS, 8'h03);
        rd(`PT_ADDR_STATUS, v);
        chk(v, 10'h000);
        wr(`PT_ADDR_CTRL0, 8'h18);
        rd(`PT_ADDR_CNT_LO, w);
        chk(w, 10'h000);
        $display("test hold done");
    endtask : t_hold
    task automatic t_cmp_pin;
        int c;
        logic [3:0] after = 4'b1100;
        for (int k = 0; k < 8; k++) begin
            cfg({2'h0, k[1:0], 1'b0, k[2], 2'h0}, 10'h002, 10'h005, 8'h18);
            repeat (2) @(posedge mclk_i);
            #1 chk(pin_o, k[2]);
            wait_irq(1'b0, c);
            chk(pin_o, after[k[1:0]] ^ k[2]);
            wait_irq(1'b0, c);
            chk(c[9:0], 10'h006);
            chk(pin_o, (k[1:0] == 2'h3) ? k[2] : after[k[1:0]] ^ k[2]);
        end
        cfg(8'h01, 10'h002, 10'h001, 8'h18);
        wait_irq(1'b0, c);
        wait_irq(1'b0, c);
        chk(c[9:0], 10'h003);
        cfg(8'hC0, 10'h002, 10'h003, 8'h18);
        repeat (3) @(posedge mclk_i);
        #1 chk(pin_en_o, 1'b0);
        $display("test compare pin done");
    endtask : t_cmp_pin
    task automatic t_pwm;
        int hi;
        int want[4] = '{0, 8, 2, 0};
        for (int k = 0; k < 4; k++) begin
            cfg({2'h2, k[1:0], 4'h9}, 10'h001, 10'h004, 8'h18);
            repeat (4) @(posedge mclk_i);
            hi = 0;
            repeat (8) begin
                @(posedge mclk_i);
                #1 hi += pin_o;
            end
            chk(hi[9:0], want[k][9:0]);
        end
        $display("test pwm done");
    endtask : t_pwm
    task automatic t_capture;
        int n;
        int want[5] = '{1, 1, 2, 0, 1};
        for (int k = 0; k < 5; k++) begin
            cfg({2'h1, k[1:0], 2'h0, k[2], 1'b0}, 10'h000, 10'h000, 8'h18);
            n = 0;
            fork
                repeat (30) begin
                    @(posedge mclk_i);
                    #1 n += irq_a;
                end
                if (k == 4) begin
                    u_pt_pins_model.ext_run = 1'b1;
                    @(posedge ext_pin);
                    u_pt_pins_model.ext_run = 1'b0;
                end else begin
                    u_pt_pins_model.set_cap(1'b1);
                    repeat (8) @(posedge mclk_i);
                    u_pt_pins_model.set_cap(1'b0);
                end
            join
            chk(n[9:0], want[k][9:0]);
        end
        $display("test capture done");
    endtask : t_capture
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    // hang guard, well above the few thousand cycles the tests need
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            finish_test;
        end
    end
    initial begin
        repeat (16) @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_regs;
        t_clocks;
        t_hold;
        t_cmp_pin;
        t_pwm;
        t_capture;
        finish_test;
    end
endmodule : periodic_timer_module_tb
bind pt_timer pt_chk u_pt_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .timer_output_pin_o(timer_output_pin_o), .timer_output_pin_en_o(timer_output_pin_en_o),
    .inverted_output_pin_o(inverted_output_pin_o), .compare_a_irq_o(compare_a_irq_o),
    .compare_p_irq_o(compare_p_irq_o));
